// ===== rtl/frd_pkg.sv
// Package with the constants, field tables and carrier types of the flame relay decision block.
package frd_pkg;

  localparam int READ_W = 10;
  localparam int CNT_W  = 14;
  localparam int NFILE  = 8;
  localparam int NFLD   = 11;

  // Seconds and the derived cycle count at 125 MHz.
  localparam int CLK_HZ        = 125_000_000;
  localparam int ONE_SEC_S     = 1;
  localparam int TICKS_PER_SEC = ONE_SEC_S * CLK_HZ;

  localparam logic [CNT_W-1:0] SAT_COUNT = 14'h270f;
  localparam logic [CNT_W-1:0] MAX_RANGE = 14'h270e;

  // Register numbers as seen on the serial side.
  localparam logic [15:0] REG_FLAMECOUNT  = 16'h9c41;
  localparam logic [15:0] REG_ON_SET      = 16'h9c43;
  localparam logic [15:0] REG_OFF_SET     = 16'h9c45;
  localparam logic [15:0] REG_MA_GAIN     = 16'h9c47;
  localparam logic [15:0] REG_IR_GAIN     = 16'h9c49;
  localparam logic [15:0] REG_IR_FILT     = 16'h9c4b;
  localparam logic [15:0] REG_UVT_GAIN    = 16'h9c4c;
  localparam logic [15:0] REG_SS_FILT     = 16'h9c4f;
  localparam logic [15:0] REG_SS_GAIN     = 16'h9c50;
  localparam logic [15:0] REG_ON_DELAY    = 16'h9c55;
  localparam logic [15:0] REG_FLAME_FAILURE_RESPONSE_TIME        = 16'h9c56;
  localparam logic [15:0] REG_PANEL_TO    = 16'h9c59;
  localparam logic [15:0] REG_ACTIVE_FILE = 16'h9c9d;
  localparam logic [15:0] REG_UVT_COUNT   = 16'h9c9f;
  localparam logic [15:0] REG_IR_COUNT    = 16'h9ca0;
  localparam logic [15:0] REG_SS_COUNT    = 16'h9ca1;
  localparam logic [15:0] REG_FILE_BASE   = 16'h9ca4;
  localparam logic [15:0] REG_FILE_LAST   = 16'h9cf3;
  localparam logic [15:0] FILE_STRIDE     = 16'h000a;
  localparam logic [15:0] ACTIVE_FILE_RST = 16'h0000;

  // Field index inside one parameter file.
  localparam logic [3:0] F_ON = 4'h0, F_OFF = 4'h1, F_FLAME_FAILURE_RESPONSE_TIME = 4'h2, F_DLY = 4'h3;
  localparam logic [3:0] F_UVT_G = 4'h4, F_SS_G = 4'h5, F_SS_F = 4'h6, F_IR_F = 4'h7;
  localparam logic [3:0] F_IR_G = 4'h8, F_MA_G = 4'h9, F_PTO = 4'ha;

  localparam logic [15:0] FLD_DEF [NFLD] = '{16'h00c8, 16'h0064, 16'h0001, 16'h0003,
      16'h0032, 16'h0000, 16'h0003, 16'h0003, 16'h0019, 16'h001e, 16'h000a};
  localparam logic [15:0] FLD_MIN [NFLD] = '{16'h0033, 16'h0032, 16'h0001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] FLD_MAX [NFLD] = '{16'h0d61, 16'h0d60, 16'h0003, 16'h0003,
      16'h0063, 16'h0063, 16'h0009, 16'h0009, 16'h0063, 16'h0063, 16'h270f};

  // High-pass cutoff in Hz for flicker settings 0 to 9.
  localparam logic [8:0] CUTOFF_HZ [10] = '{9'h009, 9'h010, 9'h018, 9'h021, 9'h034,
      9'h04b, 9'h064, 9'h09b, 9'h0d7, 9'h12c};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } frd_req_t;

  typedef struct packed {
    logic [READ_W-1:0] uvt;
    logic [READ_W-1:0] solid_state_ultraviolet;
    logic [READ_W-1:0] ir;
  } frd_sens_t;

endpackage

// ===== rtl/frd_flame_relay.sv
// Flame count, relay decision, parameter files and serial register access.
`timescale 1ns/10ps

module frd_flame_relay #(
  parameter int TICKS_PER_SEC = frd_pkg::TICKS_PER_SEC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire frd_pkg::frd_sens_t     sens,
  input  wire logic [2:0]             sens_present,
  input  wire logic                   selfcheck_fault,
  input  wire logic                   lockout_clear,
  input  wire logic                   file_sel_in,
  output logic                        file_sel_out,
  input  wire frd_pkg::frd_req_t      req,
  output logic                        rsp_ack,
  output logic                        rsp_err,
  output logic [15:0]                 rsp_rdata,
  output logic                        flame_relay,
  output logic                        selfcheck_relay,
  output logic [frd_pkg::CNT_W-1:0]   flame_count,
  output logic [20:0]                 current_level,
  output logic [8:0]                  solid_uv_cutoff_hz,
  output logic [8:0]                  infrared_cutoff_hz,
  output logic [2:0]                  file_in_use
);

  typedef enum logic [4:0] {
    FRD_OFF      = 5'b00001,
    FRD_PEND_ON  = 5'b00010,
    FRD_ON       = 5'b00100,
    FRD_PEND_OFF = 5'b01000,
    FRD_LOCK     = 5'b10000
  } frd_state_t;

  frd_state_t         state;
  logic [15:0]        pmem [frd_pkg::NFILE][frd_pkg::NFLD];
  logic [15:0]        active_low_input_file;
  logic [16:0]        scaled [3];
  logic [18:0]        raw_sum;
  logic [frd_pkg::CNT_W-1:0] uvt_count, ss_count, ir_count;
  logic               above_on, below_off, tmr_done, tmr_run;
  logic [31:0]        tmr_cyc;
  logic [1:0]         tmr_sec, tmr_goal;
  logic [2:0]         acc_file;
  logic [3:0]         acc_fld;
  logic               acc_hit, wr_ok;
  logic [15:0]        idx;

  // In-use file selection.
  // selection mux
  always_comb begin
    file_in_use = file_sel_in ? 3'h1 : active_low_input_file[2:0];
  end

  // Register request decode: global shortcuts act on the file in use.
  always_comb begin
    idx = req.addr - frd_pkg::REG_FILE_BASE;
    acc_hit = 1'b1;
    acc_file = file_in_use;
    acc_fld = frd_pkg::F_ON;
    case (req.addr)
      frd_pkg::REG_ON_SET:   acc_fld = frd_pkg::F_ON;
      frd_pkg::REG_OFF_SET:  acc_fld = frd_pkg::F_OFF;
      frd_pkg::REG_MA_GAIN:  acc_fld = frd_pkg::F_MA_G;
      frd_pkg::REG_IR_GAIN:  acc_fld = frd_pkg::F_IR_G;
      frd_pkg::REG_IR_FILT:  acc_fld = frd_pkg::F_IR_F;
      frd_pkg::REG_UVT_GAIN: acc_fld = frd_pkg::F_UVT_G;
      frd_pkg::REG_SS_FILT:  acc_fld = frd_pkg::F_SS_F;
      frd_pkg::REG_SS_GAIN:  acc_fld = frd_pkg::F_SS_G;
      frd_pkg::REG_ON_DELAY: acc_fld = frd_pkg::F_DLY;
      frd_pkg::REG_FLAME_FAILURE_RESPONSE_TIME:     acc_fld = frd_pkg::F_FLAME_FAILURE_RESPONSE_TIME;
      frd_pkg::REG_PANEL_TO: acc_fld = frd_pkg::F_PTO;
      default: begin
        if (req.addr >= frd_pkg::REG_FILE_BASE && req.addr <= frd_pkg::REG_FILE_LAST) begin
          acc_file = 3'(idx / frd_pkg::FILE_STRIDE);
          acc_fld = 4'(idx % frd_pkg::FILE_STRIDE);
        end else begin
          acc_hit = 1'b0;
        end
      end
    endcase
  end

  // Range checks, and the on/off pair must keep at least one count apart.
  // threshold limits
  always_comb begin
    wr_ok = req.wdata >= frd_pkg::FLD_MIN[acc_fld] && req.wdata <= frd_pkg::FLD_MAX[acc_fld];
    if (acc_fld == frd_pkg::F_ON) begin
      wr_ok = wr_ok && req.wdata > pmem[acc_file][frd_pkg::F_OFF];
    end else if (acc_fld == frd_pkg::F_OFF) begin
      wr_ok = wr_ok && req.wdata < pmem[acc_file][frd_pkg::F_ON];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int f = 0; f < frd_pkg::NFILE; f++) begin
        for (int k = 0; k < frd_pkg::NFLD; k++) begin
          pmem[f][k] <= frd_pkg::FLD_DEF[k];
        end
      end
    end else if (req.wr && acc_hit && wr_ok) begin
      pmem[acc_file][acc_fld] <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_low_input_file <= frd_pkg::ACTIVE_FILE_RST;
    end else if (req.wr && req.addr == frd_pkg::REG_ACTIVE_FILE && req.wdata < 16'h0008) begin
      active_low_input_file <= req.wdata;
    end
  end

  // Answer one cycle after the request; bad address or value gives an error pulse.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ack <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_ack <= 1'b0;
      rsp_err <= 1'b0;
      if (req.rd) begin
        rsp_ack <= 1'b1;
        case (req.addr)
          frd_pkg::REG_FLAMECOUNT:  rsp_rdata <= 16'(flame_count);
          frd_pkg::REG_ACTIVE_FILE: rsp_rdata <= active_low_input_file;
          frd_pkg::REG_UVT_COUNT:   rsp_rdata <= 16'(uvt_count);
          frd_pkg::REG_SS_COUNT:    rsp_rdata <= 16'(ss_count);
          frd_pkg::REG_IR_COUNT:    rsp_rdata <= 16'(ir_count);
          default: begin
            rsp_rdata <= acc_hit ? pmem[acc_file][acc_fld] : 16'h0000;
            rsp_err <= !acc_hit;
          end
        endcase
      end else if (req.wr) begin
        rsp_ack <= 1'b1;
        if (req.addr == frd_pkg::REG_ACTIVE_FILE) begin
          rsp_err <= req.wdata >= 16'h0008;
        end else begin
          rsp_err <= !(acc_hit && wr_ok);
        end
      end
    end
  end

  // A sensor with gain zero or not fitted contributes nothing.
  // scaled readings
  always_comb begin
    scaled[0] = sens_present[0] ? sens.uvt * pmem[file_in_use][frd_pkg::F_UVT_G][6:0] : '0;
    scaled[1] = sens_present[1] ? sens.solid_state_ultraviolet * pmem[file_in_use][frd_pkg::F_SS_G][6:0] : '0;
    scaled[2] = sens_present[2] ? sens.ir * pmem[file_in_use][frd_pkg::F_IR_G][6:0] : '0;
    raw_sum = 19'(scaled[0]) + 19'(scaled[1]) + 19'(scaled[2]);
  end

  // The decision runs on the saturated count so 9999 always reads as flame.
  // saturation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flame_count <= '0;
      uvt_count <= '0;
      ss_count <= '0;
      ir_count <= '0;
    end else begin
      flame_count <= raw_sum > 19'(frd_pkg::MAX_RANGE) ? frd_pkg::SAT_COUNT : 14'(raw_sum);
      uvt_count <= scaled[0] > 17'(frd_pkg::MAX_RANGE) ? frd_pkg::SAT_COUNT : 14'(scaled[0]);
      ss_count <= scaled[1] > 17'(frd_pkg::MAX_RANGE) ? frd_pkg::SAT_COUNT : 14'(scaled[1]);
      ir_count <= scaled[2] > 17'(frd_pkg::MAX_RANGE) ? frd_pkg::SAT_COUNT : 14'(scaled[2]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_level <= '0;
      solid_uv_cutoff_hz <= frd_pkg::CUTOFF_HZ[3];
      infrared_cutoff_hz <= frd_pkg::CUTOFF_HZ[3];
    end else begin
      current_level <= flame_count * pmem[file_in_use][frd_pkg::F_MA_G][6:0];
      solid_uv_cutoff_hz <= frd_pkg::CUTOFF_HZ[pmem[file_in_use][frd_pkg::F_SS_F][3:0]];
      infrared_cutoff_hz <= frd_pkg::CUTOFF_HZ[pmem[file_in_use][frd_pkg::F_IR_F][3:0]];
    end
  end

  assign above_on = 16'(flame_count) > pmem[file_in_use][frd_pkg::F_ON];
  assign below_off = 16'(flame_count) < pmem[file_in_use][frd_pkg::F_OFF];
  assign tmr_goal = state == FRD_PEND_ON ? pmem[file_in_use][frd_pkg::F_DLY][1:0]
                                         : pmem[file_in_use][frd_pkg::F_FLAME_FAILURE_RESPONSE_TIME][1:0];
  assign tmr_done = tmr_sec == tmr_goal;
  assign tmr_run = (state == FRD_PEND_ON && above_on) || (state == FRD_PEND_OFF && below_off);

  // Seconds timer, cleared whenever a pending phase is not running.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_cyc <= '0;
      tmr_sec <= '0;
    end else if (!tmr_run) begin
      tmr_cyc <= '0;
      tmr_sec <= '0;
    end else if (!tmr_done) begin
      if (tmr_cyc == 32'(TICKS_PER_SEC - 1)) begin
        tmr_cyc <= '0;
        tmr_sec <= tmr_sec + 2'h1;
      end else begin
        tmr_cyc <= tmr_cyc + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FRD_OFF;
    end else if (selfcheck_fault) begin
      state <= FRD_LOCK;
    end else begin
      case (state)
        FRD_OFF:      state <= above_on ? FRD_PEND_ON : FRD_OFF;
        FRD_PEND_ON:  state <= !above_on ? FRD_OFF : (tmr_done ? FRD_ON : FRD_PEND_ON);
        FRD_ON:       state <= below_off ? FRD_PEND_OFF : FRD_ON;
        FRD_PEND_OFF: state <= !below_off ? FRD_ON : (tmr_done ? FRD_OFF : FRD_PEND_OFF);
        FRD_LOCK:     state <= lockout_clear ? FRD_OFF : FRD_LOCK;
        default:      state <= FRD_LOCK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flame_relay <= 1'b0;
      selfcheck_relay <= 1'b0;
      file_sel_out <= 1'b0;
    end else begin
      // relay and feedback outputs
      // The relay follows the next state, so it opens on the edge that the state leaves.
      flame_relay <= !selfcheck_fault && (state == FRD_ON ||
                     (state == FRD_PEND_OFF && !(below_off && tmr_done)) ||
                     (state == FRD_PEND_ON && above_on && tmr_done));
      selfcheck_relay <= !selfcheck_fault && state != FRD_LOCK;
      file_sel_out <= file_sel_in;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FAULT_OPENS: assert property (selfcheck_fault |=> !flame_relay && !selfcheck_relay)
    else $error("Fault did not open both relays.");
  AST_MIRROR: assert property (##1 file_sel_out == $past(file_sel_in))
    else $error("Feedback does not follow select input.");
  AST_FILE_ONE: assert property (file_sel_in |-> file_in_use == 3'h1)
    else $error("High select input did not choose file 1.");
  AST_LOW_FILE_RANGE: assert property (active_low_input_file < 16'h0008)
    else $error("Low-input file out of range.");
  AST_RELAY_STATE: assert property (
      flame_relay |-> state == FRD_ON || state == FRD_PEND_OFF)
    else $error("Relay closed outside flame-on state.");
  AST_ON_NEEDS_ABOVE: assert property ($rose(flame_relay) |-> $past(above_on, 2))
    else $error("Relay closed without count above on threshold.");
  AST_OFF_CAUSE: assert property (
      $fell(flame_relay) |-> $past(below_off, 2) || $past(selfcheck_fault))
    else $error("Relay opened without low count or fault.");
  AST_ON_RESTART: assert property (
      state == FRD_PEND_ON && !above_on && !selfcheck_fault |=> state == FRD_OFF)
    else $error("On-delay did not restart.");
  AST_OFF_RESTART: assert property (
      state == FRD_PEND_OFF && !below_off && !selfcheck_fault |=> state == FRD_ON)
    else $error("Response timer did not restart.");
  AST_SATURATE: assert property (
      raw_sum > 19'(frd_pkg::MAX_RANGE) |=> flame_count == frd_pkg::SAT_COUNT)
    else $error("Over-range count not saturated.");

  COV_FLAME_ON: cover property ($rose(flame_relay));
  COV_FLAME_OFF: cover property (state == FRD_PEND_OFF ##1 state == FRD_OFF);
  COV_LOCKOUT: cover property (state == FRD_LOCK ##1 state == FRD_OFF);
  COV_FILE_SWITCH: cover property ($rose(file_sel_in));

endmodule

// ===== sim/frd_burner_ctl.sv
// Burner control side: drives the file-select wire and watches its feedback.
`timescale 1ns/10ps
module frd_burner_ctl (
  input  wire logic clk,
  input  wire logic file_sel_out,
  output logic      file_sel_in,
  output int        fb_errs,
  output int        fb_checks
);
  initial begin
    file_sel_in = 1'b0;
    fb_errs = 0;
    fb_checks = 0;
  end

  task automatic set_sel(input logic v);
    @(negedge clk);
    file_sel_in = v;
    repeat (2) @(negedge clk);
    fb_checks++;
    if (file_sel_out !== v) begin
      fb_errs++;
      $display("BAD file_sel_out exp %0h got %0h", v, file_sel_out);
    end
  endtask
endmodule

// ===== sim/test_flame_relay_decision.sv
// Self-checking bench for the flame relay decision block.
`timescale 1ns/10ps
module test_flame_relay_decision;
  localparam int TPS = 4;
  logic               clk;
  logic               rst_n;
  frd_pkg::frd_sens_t sens;
  logic [2:0]         present;
  logic               fault;
  logic               clr;
  logic               sel;
  logic               sel_fb;
  frd_pkg::frd_req_t  req;
  logic               ack;
  logic               err;
  logic [15:0]        rdata;
  logic               relay;
  logic               sc_relay;
  logic [13:0]        count;
  logic [20:0]        level;
  logic [8:0]         ss_hz;
  logic [8:0]         ir_hz;
  logic [2:0]         in_use;
  int                 errors;
  int                 compares;
  int                 fb_errs;
  int                 fb_checks;
  int                 n;
  logic [15:0]        dflt [10] = '{16'h00c8, 16'h0064, 16'h0001, 16'h0003, 16'h0032,
                                    16'h0000, 16'h0003, 16'h0003, 16'h0019, 16'h001e};
  logic [8:0]         hz [10] = '{9'h009, 9'h010, 9'h018, 9'h021, 9'h034, 9'h04b,
                                  9'h064, 9'h09b, 9'h0d7, 9'h12c};
  logic [15:0]        bad_a [15] = '{16'h9c4f, 16'h9c4b, 16'h9c4c, 16'h9c50, 16'h9c49,
      16'h9c47, 16'h9c56, 16'h9c56, 16'h9c55, 16'h9c43, 16'h9c45, 16'h9c45, 16'h9c43,
      16'h9c9d, 16'h9c42};
  logic [15:0]        bad_d [15] = '{16'h000a, 16'h000a, 16'h0064, 16'h0064, 16'h0064,
      16'h0064, 16'h0000, 16'h0004, 16'h0004, 16'h0d62, 16'h0031, 16'h00c8, 16'h0064,
      16'h0008, 16'h0000};

  frd_flame_relay #(.TICKS_PER_SEC(TPS)) frd_flame_relay_i (
    .clk(clk), .rst_n(rst_n), .sens(sens), .sens_present(present),
    .selfcheck_fault(fault), .lockout_clear(clr), .file_sel_in(sel),
    .file_sel_out(sel_fb), .req(req), .rsp_ack(ack), .rsp_err(err), .rsp_rdata(rdata),
    .flame_relay(relay), .selfcheck_relay(sc_relay), .flame_count(count),
    .current_level(level), .solid_uv_cutoff_hz(ss_hz), .infrared_cutoff_hz(ir_hz),
    .file_in_use(in_use));

  frd_burner_ctl frd_burner_ctl_i (
    .clk(clk), .file_sel_out(sel_fb), .file_sel_in(sel), .fb_errs(fb_errs),
    .fb_checks(fb_checks));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask

  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        input logic ex_err);
    @(negedge clk);
    req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    chk("ack", 1'b1, ack);
    chk("err", ex_err, err);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000, 1'b0);
    chk("rdata", exp, rdata);
  endtask

  task automatic put(input logic [9:0] u, input logic [9:0] s, input logic [9:0] i);
    @(negedge clk);
    sens = '{uvt: u, solid_state_ultraviolet: s, ir: i};
  endtask

  // The lag is counted in cycles from the edge that changed the readings.
  task automatic wait_relay(input logic want, input int lo, input int hi);
    n = 0;
    while (relay !== want && n <= hi) begin
      @(negedge clk);
      n++;
    end
    chk("relay_lag_ok", 1'b1, n >= lo && n <= hi);
  endtask

  task automatic wrap_up();
    errors += fb_errs;
    compares += fb_checks;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    sens = '0;
    present = 3'b111;
    fault = 1'b0;
    clr = 1'b0;
    req = '0;
    errors = 0;
    compares = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    for (int k = 0; k < 10; k++) rd(16'h9ca4 + 16'(k), dflt[k]);
    rd(16'h9c9d, 16'h0000);
    for (int k = 0; k < 15; k++) access(1'b1, bad_a[k], bad_d[k], 1'b1);
    rd(16'h9c43, 16'h00c8);
    rd(16'h9c45, 16'h0064);
    for (int k = 0; k < 10; k++) begin
      access(1'b1, 16'h9c4f, 16'(k), 1'b0);
      access(1'b1, 16'h9c4b, 16'(9 - k), 1'b0);
      @(negedge clk);
      chk("ss_hz", hz[k], ss_hz);
      chk("ir_hz", hz[9 - k], ir_hz);
    end
    access(1'b1, 16'h9c43, 16'h0d61, 1'b0);
    access(1'b1, 16'h9c45, 16'h0d60, 1'b0);
    access(1'b1, 16'h9c45, 16'h0032, 1'b0);
    access(1'b1, 16'h9c43, 16'h0033, 1'b0);
    put(10'h000, 10'h3ff, 10'h000);
    repeat (3) @(negedge clk);
    chk("count_solid_state_ultraviolet_off", 14'h0000, count);
    put(10'h014, 10'h000, 10'h000);
    repeat (3) @(negedge clk);
    chk("count_uvt", 14'h03e8, count);
    put(10'h000, 10'h000, 10'h028);
    repeat (3) @(negedge clk);
    chk("count_ir", 14'h03e8, count);
    present = 3'b011;
    repeat (3) @(negedge clk);
    chk("count_absent", 14'h0000, count);
    present = 3'b111;
    put(10'h014, 10'h000, 10'h028);
    repeat (3) @(negedge clk);
    chk("count", 14'h07d0, count);
    chk("level", 21'h00ea60, level);
    rd(16'h9c41, 16'h07d0);
    rd(16'h9c9f, 16'h03e8);
    rd(16'h9ca0, 16'h03e8);
    put(10'h000, 10'h000, 10'h000);
    repeat (3) @(negedge clk);
    put(10'h3ff, 10'h000, 10'h3ff);
    repeat (8) @(negedge clk);
    chk("count_sat", 14'h270f, count);
    put(10'h000, 10'h000, 10'h000);
    repeat (3) @(negedge clk);
    chk("relay", 1'b0, relay);
    put(10'h3ff, 10'h000, 10'h3ff);
    wait_relay(1'b1, 3 * TPS + 2, 3 * TPS + 6);
    put(10'h000, 10'h000, 10'h000);
    repeat (3) @(negedge clk);
    put(10'h3ff, 10'h000, 10'h3ff);
    repeat (10) @(negedge clk);
    chk("relay", 1'b1, relay);
    put(10'h000, 10'h000, 10'h000);
    wait_relay(1'b0, TPS + 2, TPS + 6);
    put(10'h3ff, 10'h000, 10'h3ff);
    wait_relay(1'b1, 3 * TPS + 2, 3 * TPS + 6);
    @(negedge clk) fault = 1'b1;
    repeat (2) @(negedge clk);
    chk("relay", 1'b0, relay);
    chk("sc_relay", 1'b0, sc_relay);
    fault = 1'b0;
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    put(10'h000, 10'h000, 10'h000);
    chk("sc_relay", 1'b1, sc_relay);
    access(1'b1, 16'h9cb1, 16'h0000, 1'b0);
    access(1'b1, 16'h9caf, 16'h0032, 1'b0);
    access(1'b1, 16'h9cae, 16'h0033, 1'b0);
    access(1'b1, 16'h9c9d, 16'h0007, 1'b0);
    rd(16'h9c9d, 16'h0007);
    chk("in_use", 3'h7, in_use);
    rd(16'h9c55, 16'h0003);
    frd_burner_ctl_i.set_sel(1'b1);
    chk("in_use", 3'h1, in_use);
    rd(16'h9c55, 16'h0000);
    put(10'h3ff, 10'h000, 10'h3ff);
    wait_relay(1'b1, 2, 6);
    put(10'h000, 10'h000, 10'h000);
    wait_relay(1'b0, TPS + 2, TPS + 6);
    frd_burner_ctl_i.set_sel(1'b0);
    chk("in_use", 3'h7, in_use);
    wrap_up();
  end
endmodule
